// ===== common/bckc_pkg.sv
// constants, encodings and types of the buck converter control block
// assumes a 100 MHz system clock driving all of the block's logic
package bckc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MINP_STEP_NS = 20;
  localparam int MINP_STEP_CYC = (MINP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_BASE = 8;

  // ****************************************
  // mode register
  // ****************************************
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_LARGE_BIT = 1;
  localparam int MODE_MINP_LSB = 2;
  localparam int MINP_W = 2;
  localparam int MODE_ILIM_LSB = 4;
  localparam int ILIM_W = 3;
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam logic [2:0] ILIM_200MA = 3'h1;
  localparam logic [2:0] ILIM_300MA = 3'h2;
  localparam logic [2:0] ILIM_400MA = 3'h3;
  localparam logic [2:0] ILIM_500MA = 3'h4;
  localparam logic [2:0] ILIM_600MA = 3'h5;

  // ****************************************
  // config, level and ready registers
  // ****************************************
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_INV_BIT = 3;
  localparam int CFG_DIV_LSB = 5;
  localparam int DIV_W = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int LVL_LSB = 3;
  localparam int LVL_W = 4;
  localparam logic [7:0] LVL_RESET = 8'h08;
  localparam logic [3:0] LVL_1V9 = 4'h1;
  localparam int LVL_BASE_MV = 1800;
  localparam int LVL_STEP_MV = 100;
  localparam int RDY_HIGH_BIT = 7;
  localparam int RDY_LOW_BIT = 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN
  } bckc_state_t;

endpackage : bckc_pkg

// ===== common/bckc_clk_if.sv
// switching clock path between the control core and the clock selector
// assumes every signal is a level on the system clock
`timescale 1ns/10ps
`default_nettype none
interface bckc_clk_if;
  logic osc_lvl;
  logic div_lvl;
  logic sel_sys;
  logic sw_lvl;
  modport mux (input osc_lvl, input div_lvl, input sel_sys, output sw_lvl);
  modport ctrl (output osc_lvl, output div_lvl, output sel_sys, input sw_lvl);
endinterface : bckc_clk_if
`default_nettype wire

// ===== hw/bckc_sync.sv
// two-stage synchroniser for a bank of pin inputs
// assumes the inputs are asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module bckc_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : bckc_sync
`default_nettype wire

// ===== hw/bckc_clk_mux.sv
// glitch-free selector between oscillator and divided system clock
// assumes both inputs are registered levels on the system clock
`timescale 1ns/10ps
`default_nettype none
module bckc_clk_mux (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  bckc_clk_if.mux cif
);
  logic cur_sys_r;
  logic park_r;
  logic osc_prev_r;
  logic div_prev_r;
  logic sw_r;
  logic cur_lvl;
  logic new_lvl;
  logic new_fell;

  assign cur_lvl = cur_sys_r ? cif.div_lvl : cif.osc_lvl;
  assign new_lvl = cif.sel_sys ? cif.div_lvl : cif.osc_lvl;
  // a fall of the wanted source starts a full low phase of it
  assign new_fell = cif.sel_sys ? (div_prev_r && !cif.div_lvl) : (osc_prev_r && !cif.osc_lvl);

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      osc_prev_r <= 1'b0;
      div_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= cif.osc_lvl;
      div_prev_r <= cif.div_lvl;
    end
  end

  // park low, resume on a fall
  // a change may wait one period of the new source; a short low would be worse
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cur_sys_r <= 1'b0;
      park_r <= 1'b0;
    end else if (park_r) begin
      if (new_fell) begin
        cur_sys_r <= cif.sel_sys;
        park_r <= 1'b0;
      end
    end else if (cif.sel_sys != cur_sys_r && !cur_lvl) begin
      park_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sw_r <= 1'b0;
    end else begin
      sw_r <= !park_r && cur_lvl;
    end
  end

  assign cif.sw_lvl = sw_r;

  property p_no_runt;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(sw_r) |=> sw_r;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("switching clock high for one cycle only");

  property p_hold_sel;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!park_r || new_lvl) |=> $stable(cur_sys_r);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("source changed while a clock was high");

  property p_park_low;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      park_r |=> !sw_r;
  endproperty
  a_park_low: assert property (p_park_low) else $error("switching clock not held low while parked");
endmodule : bckc_clk_mux
`default_nettype wire

// ===== hw/bckc_ctrl.sv
// digital control of the on-chip step-down converter
// assumes comparator and oscillator pins are asynchronous; demand comes from
// a loop filter clocked by sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module bckc_ctrl #(
  parameter int DEMAND_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic mode_wr_i,
  input wire logic [7:0] mode_data_i,
  input wire logic config_wr_i,
  input wire logic [7:0] config_data_i,
  input wire logic level_wr_i,
  input wire logic [7:0] level_data_i,
  input wire logic osc_clk_i,
  input wire logic vout_above_i,
  input wire logic near_high_i,
  input wire logic near_low_i,
  input wire logic peak_over_i,
  input wire logic [DEMAND_W-1:0] demand_i,
  output logic [7:0] mode_reg_o,
  output logic [7:0] config_reg_o,
  output logic [7:0] level_reg_o,
  output logic [7:0] ready_reg_o,
  output logic [bckc_pkg::LVL_W-1:0] level_code_o,
  output logic [bckc_pkg::ILIM_W-1:0] peak_limit_code_o,
  output logic large_switch_o,
  output logic high_side_switch_o,
  output logic low_side_switch_o,
  output logic sw_clk_o,
  output logic skip_o,
  output logic active_o
);
  import bckc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] div_half(input logic [DIV_W-1:0] code);
    div_half = 9'((DIV_BASE / 2) << code);
  endfunction : div_half

  function automatic logic [DEMAND_W-1:0] min_width(input logic [MINP_W-1:0] code);
    min_width = DEMAND_W'(int'(code) * MINP_STEP_CYC);
  endfunction : min_width

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] mode_r;
  logic [7:0] cfg_r;
  logic [7:0] lvl_r;
  logic [7:0] ready_r;
  bckc_state_t state_r;
  logic [8:0] div_cnt_r;
  logic div_raw_r;
  logic div_out_r;
  logic sw_prev_r;
  logic hs_r;
  logic ls_r;
  logic skip_r;
  logic [DEMAND_W-1:0] on_cnt_r;
  logic [3:0] pins_s;
  logic osc_s;
  logic above_s;
  logic peak_s;
  logic en;
  logic sw_rise;
  logic [MINP_W-1:0] minp;
  logic [DIV_W-1:0] div_code;

  bckc_clk_if cif ();

  // field layout of the mode word
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_RESET;
    end else if (mode_wr_i) begin
      mode_r <= mode_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cfg_r <= CFG_RESET;
    end else if (config_wr_i) begin
      cfg_r <= config_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lvl_r <= LVL_RESET;
    end else if (level_wr_i) begin
      lvl_r <= level_data_i;
    end
  end

  assign en = mode_r[MODE_EN_BIT];
  assign minp = mode_r[MODE_MINP_LSB +: MINP_W];
  assign div_code = cfg_r[CFG_DIV_LSB +: DIV_W];

  // ****************************************
  // pin synchronisers
  // ****************************************
  bckc_sync #(
    .W(4)
  ) u_sync_cmp (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({vout_above_i, peak_over_i, near_high_i, near_low_i}),
    .q_o(pins_s)
  );

  bckc_sync #(
    .W(1)
  ) u_sync_osc (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(osc_clk_i),
    .q_o(osc_s)
  );

  assign above_s = pins_s[3];
  assign peak_s = pins_s[2];

  // ready flags mirror the window comparators
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ready_r <= 8'h00;
    end else begin
      ready_r <= 8'h00;
      ready_r[RDY_HIGH_BIT] <= pins_s[1];
      ready_r[RDY_LOW_BIT] <= pins_s[0];
    end
  end

  // ****************************************
  // switching clock path
  // ****************************************
  // divider toggles at half the divisor; a new setting acts on the count in progress at once
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      div_cnt_r <= 9'h000;
      div_raw_r <= 1'b0;
    end else if (div_cnt_r + 9'h001 >= div_half(div_code)) begin
      div_cnt_r <= 9'h000;
      div_raw_r <= ~div_raw_r;
    end else begin
      div_cnt_r <= div_cnt_r + 9'h001;
    end
  end

  // inversion applied only at a toggle so no runt pulse
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      div_out_r <= 1'b0;
    end else if (div_cnt_r + 9'h001 >= div_half(div_code)) begin
      div_out_r <= (~div_raw_r) ^ cfg_r[CFG_INV_BIT];
    end
  end

  assign cif.osc_lvl = osc_s;
  assign cif.div_lvl = div_out_r;
  assign cif.sel_sys = cfg_r[CFG_SRC_BIT];

  bckc_clk_mux u_clk_mux (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .cif(cif)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sw_prev_r <= 1'b0;
    end else begin
      sw_prev_r <= cif.sw_lvl;
    end
  end

  assign sw_rise = cif.sw_lvl && !sw_prev_r;

  // ****************************************
  // sequencing
  // ****************************************
  // enable gates the sequencer and both switches
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (en) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (!en) begin
            state_r <= ST_IDLE;
          end else if (above_s) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // high-side switch and pulse timing
  // ****************************************
  // hazard: limit and overvoltage override any pulse in flight
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      hs_r <= 1'b0;
      on_cnt_r <= '0;
    end else if (!en || state_r == ST_IDLE) begin
      hs_r <= 1'b0;
      on_cnt_r <= '0;
    end else if (peak_s || above_s) begin
      hs_r <= 1'b0;
      on_cnt_r <= '0;
    end else if (state_r == ST_START) begin
      hs_r <= 1'b1;
    end else if (sw_rise) begin
      if (demand_i == '0 || (minp != '0 && demand_i < min_width(minp))) begin
        hs_r <= 1'b0;
        on_cnt_r <= '0;
      end else begin
        hs_r <= 1'b1;
        on_cnt_r <= demand_i;
      end
    end else if (on_cnt_r > DEMAND_W'(1)) begin
      on_cnt_r <= on_cnt_r - DEMAND_W'(1);
    end else begin
      hs_r <= 1'b0;
      on_cnt_r <= '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= en && state_r == ST_RUN && sw_rise && !peak_s && !above_s && demand_i != '0
                && minp != '0 && demand_i < min_width(minp);
    end
  end

  // low side conducts between pulses; never together with the high side
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ls_r <= 1'b0;
    end else begin
      ls_r <= en && state_r == ST_RUN && !above_s && !hs_r && !sw_rise;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign mode_reg_o = mode_r;
  assign config_reg_o = cfg_r;
  assign level_reg_o = lvl_r;
  assign ready_reg_o = ready_r;
  assign level_code_o = lvl_r[LVL_LSB +: LVL_W];
  assign peak_limit_code_o = mode_r[MODE_ILIM_LSB +: ILIM_W];
  assign large_switch_o = mode_r[MODE_LARGE_BIT];
  assign high_side_switch_o = hs_r;
  assign low_side_switch_o = ls_r && !hs_r;
  assign sw_clk_o = cif.sw_lvl;
  assign skip_o = skip_r;
  assign active_o = state_r != ST_IDLE;

  // ****************************************
  // checks
  // ****************************************
  sequence s_reset_release;
    !reset_n_i ##1 reset_n_i;
  endsequence

  sequence s_skip_cause;
    en && state_r == ST_RUN && sw_rise && !peak_s && !above_s && demand_i != '0
      && minp != '0 && demand_i < min_width(minp);
  endsequence

  property p_idle_off;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      !en [*2] |-> !hs_r && !ls_r;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("switching while disabled");

  property p_start_charge;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state_r == ST_START && en && !peak_s && !above_s) |=> hs_r || !en;
  endproperty
  a_start_charge: assert property (p_start_charge) else $error("startup charge not held");

  property p_level_reset;
    @(posedge sys_clk_i) s_reset_release |-> level_code_o == LVL_1V9;
  endproperty
  a_level_reset: assert property (p_level_reset) else $error("level not 1.9 V after reset");

  property p_limit_field;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      mode_wr_i |=> peak_limit_code_o == $past(mode_data_i[MODE_ILIM_LSB +: ILIM_W]);
  endproperty
  a_limit_field: assert property (p_limit_field) else $error("limit field misplaced");

  property p_limit_reset;
    @(posedge sys_clk_i) s_reset_release |-> peak_limit_code_o == ILIM_500MA;
  endproperty
  a_limit_reset: assert property (p_limit_reset) else $error("limit not 500 mA after reset");

  property p_ready;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      ##1 ready_reg_o[RDY_HIGH_BIT] == $past(pins_s[1]) && ready_reg_o[RDY_LOW_BIT] == $past(pins_s[0]);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flags do not follow comparators");

  property p_cut;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (peak_s || above_s) |=> !hs_r;
  endproperty
  a_cut: assert property (p_cut) else $error("switch on during over-limit");

  property p_skip;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      s_skip_cause |=> skip_r && !hs_r;
  endproperty
  a_skip: assert property (p_skip) else $error("short pulse not skipped");

  property p_large;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      mode_wr_i |=> large_switch_o == $past(mode_data_i[MODE_LARGE_BIT]);
  endproperty
  a_large: assert property (p_large) else $error("switch size not applied");

  property p_inv_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (div_cnt_r + 9'h001 < div_half(div_code)) |=> $stable(div_out_r);
  endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("divided clock moved between toggles");
endmodule : bckc_ctrl
`default_nettype wire

// ===== sim/test_bckc_ctrl.sv
// self-checking bench for the buck converter control block
// assumes bckc_pkg is compiled first and the design asserts its own timing
`timescale 1ns/10ps
`default_nettype none
module test_bckc_ctrl;
  import bckc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic mode_wr_i = 1'b0;
  logic [7:0] mode_data_i = 8'h00;
  logic config_wr_i = 1'b0;
  logic [7:0] config_data_i = 8'h00;
  logic level_wr_i = 1'b0;
  logic [7:0] level_data_i = 8'h00;
  logic osc_clk_i = 1'b0;
  logic vout_above_i = 1'b0;
  logic near_high_i = 1'b0;
  logic near_low_i = 1'b0;
  logic peak_over_i = 1'b0;
  logic [7:0] demand_i = 8'h00;
  logic [7:0] mode_reg_o, config_reg_o, level_reg_o, ready_reg_o;
  logic [3:0] level_code_o;
  logic [2:0] peak_limit_code_o;
  logic large_switch_o, high_side_switch_o, low_side_switch_o, sw_clk_o, skip_o, active_o;
  int fail_count = 0;
  int tests_run = 0;
  int run_len = 0;
  int short_runs = 0;
  logic mon = 1'b0;
  logic armed = 1'b0;
  logic last_sw = 1'b0;
  int n;

  bckc_ctrl #(.DEMAND_W(8)) DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mode_wr_i(mode_wr_i),
    .mode_data_i(mode_data_i), .config_wr_i(config_wr_i), .config_data_i(config_data_i),
    .level_wr_i(level_wr_i), .level_data_i(level_data_i), .osc_clk_i(osc_clk_i),
    .vout_above_i(vout_above_i), .near_high_i(near_high_i), .near_low_i(near_low_i),
    .peak_over_i(peak_over_i), .demand_i(demand_i), .mode_reg_o(mode_reg_o), .config_reg_o(config_reg_o),
    .level_reg_o(level_reg_o), .ready_reg_o(ready_reg_o), .level_code_o(level_code_o),
    .peak_limit_code_o(peak_limit_code_o), .large_switch_o(large_switch_o),
    .high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
    .sw_clk_o(sw_clk_o), .skip_o(skip_o), .active_o(active_o));

  always #5 sys_clk_i = ~sys_clk_i;
  // oscillator stand-in, 20 system cycles per half period
  // stand-in is never trimmed upward
  always #200 osc_clk_i = ~osc_clk_i;

  // count of level spans of the switching clock shorter than four cycles while monitoring
  // sampled on the falling edge so the launching edge has settled
  always @(negedge sys_clk_i) begin
    if (sw_clk_o !== last_sw) begin
      if (mon && armed && run_len < 4) short_runs++;
      armed = mon;
      run_len = 1;
    end else begin
      run_len++;
    end
    last_sw = sw_clk_o;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  function automatic logic pick(input int w);
    case (w)
      0: return high_side_switch_o;
      1: return sw_clk_o;
      2: return skip_o;
      default: return active_o;
    endcase
  endfunction : pick

  task automatic wait_val(input int w, input logic v, input int bound);
    int k;
    k = 0;
    while (pick(w) !== v) begin
      tick();
      k++;
      if (k > bound) begin
        fail_count++;
        $display("CHECK FAILED at %0t: wait on output %0d timed out", $time, w);
        give_verdict();
      end
    end
  endtask : wait_val

  // sel 0 mode, 1 config, 2 level; strobe is one cycle wide
  task automatic wr(input int sel, input logic [7:0] d);
    mode_wr_i = (sel == 0);
    config_wr_i = (sel == 1);
    level_wr_i = (sel == 2);
    mode_data_i = (sel == 0) ? d : mode_data_i;
    config_data_i = (sel == 1) ? d : config_data_i;
    level_data_i = (sel == 2) ? d : level_data_i;
    tick();
    mode_wr_i = 1'b0;
    config_wr_i = 1'b0;
    level_wr_i = 1'b0;
    // one idle edge so the next write never reassigns a strobe in this step
    tick();
  endtask : wr

  task automatic span(input int w, output int len);
    wait_val(w, 1'b0, 200);
    wait_val(w, 1'b1, 200);
    len = 0;
    while (pick(w) === 1'b1 && len < 200) begin
      tick();
      len++;
    end
    if (len >= 200) begin
      fail_count++;
      $display("CHECK FAILED at %0t: span on output %0d did not end", $time, w);
      give_verdict();
    end
  endtask : span

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(mode_reg_o, 8'h40);
    check({5'h0, peak_limit_code_o}, {5'h0, ILIM_500MA});
    check(level_reg_o, 8'h08);
    check({4'h0, level_code_o}, {4'h0, LVL_1V9});
    check(config_reg_o, 8'h00);
    check({5'h0, active_o, high_side_switch_o, low_side_switch_o}, 8'h00);
  endtask : t_reset

  task automatic t_codes();
    for (int i = 1; i <= 5; i++) begin
      wr(0, {1'b0, i[2:0], 2'b00, i[0], 1'b0});
      tick();
      check({5'h0, peak_limit_code_o}, {5'h0, i[2:0]});
      check({7'h0, large_switch_o}, {7'h0, i[0]});
      check({6'h0, active_o, high_side_switch_o}, 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      wr(2, {1'b0, i[3:0], 3'b000});
      check({4'h0, level_code_o}, {4'h0, i[3:0]});
    end
  endtask : t_codes

  task automatic t_ready();
    for (int i = 0; i < 4; i++) begin
      near_high_i = i[1];
      near_low_i = i[0];
      repeat (5) tick();
      check(ready_reg_o, {i[1:0], 6'h00});
    end
  endtask : t_ready

  task automatic t_start();
    vout_above_i = 1'b0;
    wr(0, 8'h41);
    wait_val(0, 1'b1, 6);
    repeat (10) tick();
    check({7'h0, high_side_switch_o}, 8'h01);
    peak_over_i = 1'b1;
    wait_val(0, 1'b0, 4);
    peak_over_i = 1'b0;
    wait_val(0, 1'b1, 4);
    vout_above_i = 1'b1;
    wait_val(0, 1'b0, 6);
    repeat (16) tick();
    check({7'h0, high_side_switch_o}, 8'h00);
    wr(0, 8'h40);
    wait_val(3, 1'b0, 3);
    check({7'h0, high_side_switch_o}, 8'h00);
  endtask : t_start

  task automatic t_clock();
    wr(1, 8'h01);
    span(1, n);
    check(n[7:0], 8'd4);
    mon = 1'b1;
    wr(1, 8'h21);
    span(1, n);
    span(1, n);
    check(n[7:0], 8'd8);
    wr(1, 8'h61);
    span(1, n);
    span(1, n);
    check(n[7:0], 8'd32);
    wr(1, 8'h09);
    span(1, n);
    span(1, n);
    check(n[7:0], 8'd4);
    wr(1, 8'h00);
    span(1, n);
    span(1, n);
    check({7'h0, n >= 19 && n <= 21}, 8'h01);
    mon = 1'b0;
    check(short_runs[7:0], 8'h00);
  endtask : t_clock

  task automatic t_skip();
    wr(1, 8'h01);
    demand_i = 8'd3;
    vout_above_i = 1'b1;
    wr(0, 8'h41);
    repeat (8) tick();
    vout_above_i = 1'b0;
    repeat (4) tick();
    span(0, n);
    check(n[7:0], 8'd3);
    tick();
    check({7'h0, low_side_switch_o}, 8'h01);
    // min width code 2 asks for four cycles
    wr(0, 8'h49);
    wait_val(2, 1'b1, 40);
    n = 0;
    repeat (24) begin
      tick();
      n += high_side_switch_o;
    end
    check(n[7:0], 8'd0);
    demand_i = 8'd4;
    span(0, n);
    check(n[7:0], 8'd4);
    vout_above_i = 1'b1;
    repeat (4) tick();
    wait_val(0, 1'b0, 10);
    wr(0, 8'h40);
    wait_val(3, 1'b0, 3);
    check({7'h0, low_side_switch_o}, 8'h00);
  endtask : t_skip

  initial begin
    repeat (4) tick();
    reset_n_i = 1'b1;
    t_reset();
    t_codes();
    t_ready();
    t_start();
    t_clock();
    t_skip();
    give_verdict();
  end
endmodule : test_bckc_ctrl
`default_nettype wire
